// File: hdl/dcm_params.svh
// Constants for the data channel manager
`ifndef DCM_PARAMS_SVH
`define DCM_PARAMS_SVH
`define DCM_NUM_CH 4
`define DCM_CH_W 4
`define DCM_SEL_RST 4'h1
`define DCM_NUM_LO 4'h1
`define DCM_NUM_HI 4'h4
`define DCM_PHYS_MAP 32'h08060402
`define DCM_PHYS_W 8
`define DCM_ASCII_ZERO 8'h30
`define DCM_ASCII_COMMA 8'h2c
`define DCM_LIST_LEN 3'h7
`endif

// File: hdl/dcm_pkg.sv
// Types for the data channel manager
`include "dcm_params.svh"
package dcm_pkg;
  typedef enum logic [2:0] {OP_CLOSE, OP_OPEN, OP_SELECT, OP_MAP_Q, OP_STATE_Q, OP_SEL_Q, OP_CMD_RESET} dcm_op_t;
  typedef enum logic [1:0] {MODE_RO, MODE_WO, MODE_RW, MODE_BAD} dcm_mode_t;
  typedef enum logic [2:0] {ST_CLOSED, ST_OPEN, ST_INIT, ST_RO, ST_WO, ST_RW} dcm_state_t;
  typedef enum logic {TX_IDLE, TX_SEND} dcm_tx_t;
endpackage

// File: hdl/dcm_list_if.sv
// Carrier between the command logic and the channel list serializer
`timescale 1ns/1ps
interface dcm_list_if;
  logic start;
  logic busy;
  logic byte_valid;
  logic [7:0] byte_data;
  logic byte_last;
  modport ctrl (output start, input busy, input byte_valid, input byte_data, input byte_last);
  modport tx (input start, output busy, output byte_valid, output byte_data, output byte_last);
endinterface

// File: hdl/dcm_list_tx.sv
// Serializer for the comma separated physical channel list
`timescale 1ns/1ps
`include "dcm_params.svh"
module dcm_list_tx (
  input wire logic clock,
  input wire logic rst_b,
  dcm_list_if.tx lst
);
  import dcm_pkg::*;
  localparam logic [`DCM_NUM_CH*`DCM_PHYS_W-1:0] PHYS = `DCM_PHYS_MAP;
  dcm_tx_t st_q;
  logic [2:0] pos_q;
  logic [1:0] slot;
  logic [7:0] digit;

  // Even positions carry a digit, odd ones a comma; logical order is list order
  assign slot = pos_q[2:1];
  assign digit = PHYS[slot*`DCM_PHYS_W +: `DCM_PHYS_W];

  // Walk the list one byte per cycle; numbers above nine are not supported
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= TX_IDLE;
      pos_q <= 3'h0;
      lst.busy <= 1'b0;
      lst.byte_valid <= 1'b0;
      lst.byte_data <= 8'h00;
      lst.byte_last <= 1'b0;
    end else begin
      case (st_q)
        TX_IDLE: begin
          lst.byte_valid <= 1'b0;
          lst.byte_last <= 1'b0;
          if (lst.start) begin
            st_q <= TX_SEND;
            pos_q <= 3'h0;
            lst.busy <= 1'b1;
          end
        end
        TX_SEND: begin
          lst.byte_valid <= 1'b1; // see RULE_09
          lst.byte_data <= pos_q[0] ? `DCM_ASCII_COMMA : (`DCM_ASCII_ZERO + digit); // see RULE_10
          lst.byte_last <= (pos_q == `DCM_LIST_LEN - 3'h1);
          pos_q <= pos_q + 3'h1;
          if (pos_q == `DCM_LIST_LEN - 3'h1) begin
            st_q <= TX_IDLE;
            lst.busy <= 1'b0;
          end
        end
        default: begin
          st_q <= TX_IDLE;
          lst.busy <= 1'b0;
        end
      endcase
    end
  end
endmodule

// File: hdl/dcm_top.sv
// Command interpreter for the fast data channels
//
// Contract
// RULE_01 - Close command closes the named channel, or the selected one if unnamed.
// RULE_02 - A closed channel carries no transfers; host opens before transferring.
// RULE_03 - Open command takes read, write or read-write direction for named/selected channel.
// RULE_04 - Read moves backplane data in, write moves instrument data out.
// RULE_05 - Channels owned by the meter function open only write-only.
// RULE_06 - Select sets the default channel; power-up selection is channel one.
// RULE_07 - Command reset selects channel one and opens every closed channel.
// RULE_08 - Channel numbers run from one to the channel count; host stays inside.
// RULE_09 - Map query returns comma separated physical channel numbers.
// RULE_10 - Logical channel N uses the Nth physical number of the map.
// RULE_11 - State query reports closed, open, initialized, or a direction state.
// RULE_12 - Direction states imply open and initialized; normally closed or a direction.
// RULE_13 - Selection query returns the selected channel, one to the channel count.
// RULE_14 - Bad channel number or unsupported mode is rejected, changing nothing.
`timescale 1ns/1ps
`include "dcm_params.svh"
module dcm_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire dcm_pkg::dcm_op_t cmd_op,
  input wire logic cmd_has_num,
  input wire logic [`DCM_CH_W-1:0] cmd_num,
  input wire dcm_pkg::dcm_mode_t cmd_mode,
  input wire logic [`DCM_NUM_CH-1:0] meter_owns,
  output logic resp_valid_q,
  output logic resp_reject_q,
  output dcm_pkg::dcm_state_t resp_state_q,
  output logic [`DCM_CH_W-1:0] resp_sel_q,
  output logic [`DCM_CH_W-1:0] sel_q,
  output logic [`DCM_NUM_CH-1:0] rd_enable_q,
  output logic [`DCM_NUM_CH-1:0] wr_enable_q,
  output logic map_valid,
  output logic [7:0] map_byte,
  output logic map_last,
  output logic map_busy
);
  import dcm_pkg::*;
  dcm_state_t [`DCM_NUM_CH-1:0] chan_q;
  dcm_list_if lst ();
  logic map_start_q;
  logic [`DCM_CH_W-1:0] num_eff;
  logic [`DCM_CH_W-1:0] num_off;
  logic [1:0] idx;
  logic num_ok;
  logic mode_ok;
  logic reject;
  logic take;
  dcm_state_t open_state;

  dcm_list_tx u_tx (
    .clock(clock),
    .rst_b(rst_b),
    .lst(lst)
  );

  // Serializer registers drive the list pins directly
  assign map_valid = lst.byte_valid;
  assign map_byte = lst.byte_data;
  assign map_last = lst.byte_last;
  assign map_busy = lst.busy;
  assign lst.start = map_start_q;

  // Resolve the addressed channel; unnamed commands fall back to the selection
  assign num_eff = cmd_has_num ? cmd_num : sel_q; // see RULE_01
  assign num_ok = (num_eff >= `DCM_NUM_LO) && (num_eff <= `DCM_NUM_HI); // see RULE_08
  assign num_off = num_eff - `DCM_NUM_LO;
  assign idx = num_off[1:0];

  // Direction named from the instrument side: read is backplane to instrument
  always_comb begin
    open_state = ST_WO;
    mode_ok = 1'b1;
    case (cmd_mode)
      MODE_RO: open_state = ST_RO; // see RULE_04
      MODE_WO: open_state = ST_WO;
      MODE_RW: open_state = ST_RW;
      default: mode_ok = 1'b0;
    endcase
    if (num_ok && meter_owns[idx] && cmd_mode != MODE_WO) begin
      mode_ok = 1'b0; // see RULE_05
    end
  end

  // Refuse anything that would touch state wrongly; busy list also refuses
  always_comb begin
    reject = lst.busy || map_start_q;
    case (cmd_op)
      OP_CLOSE: reject = reject || !num_ok; // see RULE_14
      OP_OPEN: reject = reject || !num_ok || !mode_ok; // see RULE_14
      OP_SELECT: reject = reject || !cmd_has_num || !num_ok; // see RULE_14
      OP_STATE_Q: reject = reject || !num_ok;
      OP_MAP_Q: reject = reject;
      OP_SEL_Q: reject = reject;
      OP_CMD_RESET: reject = reject;
      default: reject = 1'b1;
    endcase
  end
  assign take = cmd_valid && !reject;

  // Channel states; power-up opens every channel write-only, as a command reset does for closed ones
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `DCM_NUM_CH; i++) begin
        chan_q[i] <= ST_WO;
      end
    end else if (take) begin
      case (cmd_op)
        OP_CLOSE: chan_q[idx] <= ST_CLOSED; // see RULE_01
        OP_OPEN: chan_q[idx] <= open_state; // see RULE_03
        OP_CMD_RESET: begin
          for (int i = 0; i < `DCM_NUM_CH; i++) begin
            if (chan_q[i] == ST_CLOSED) begin
              chan_q[i] <= ST_WO; // see RULE_07
            end
          end
        end
        default: chan_q <= chan_q;
      endcase
    end
  end

  // Selection register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= `DCM_SEL_RST; // see RULE_06
    end else if (take && cmd_op == OP_SELECT) begin
      sel_q <= cmd_num; // see RULE_06
    end else if (take && cmd_op == OP_CMD_RESET) begin
      sel_q <= `DCM_SEL_RST; // see RULE_07
    end
  end

  // Transfer gates follow the stored direction, a cycle behind
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_enable_q <= '0;
      wr_enable_q <= '0;
    end else begin
      for (int i = 0; i < `DCM_NUM_CH; i++) begin
        rd_enable_q[i] <= (chan_q[i] == ST_RO) || (chan_q[i] == ST_RW); // see RULE_02
        wr_enable_q[i] <= (chan_q[i] == ST_WO) || (chan_q[i] == ST_RW); // see RULE_12
      end
    end
  end

  // One answer per command, one cycle later
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      resp_valid_q <= 1'b0;
      resp_reject_q <= 1'b0;
      resp_state_q <= ST_CLOSED;
      resp_sel_q <= `DCM_SEL_RST;
      map_start_q <= 1'b0;
    end else begin
      resp_valid_q <= cmd_valid;
      resp_reject_q <= cmd_valid && reject;
      map_start_q <= take && cmd_op == OP_MAP_Q; // see RULE_09
      if (take && cmd_op == OP_STATE_Q) begin
        resp_state_q <= chan_q[idx]; // see RULE_11
      end
      if (take && cmd_op == OP_SEL_Q) begin
        resp_sel_q <= sel_q; // see RULE_13
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_close_channel: assert property (take && cmd_op == OP_CLOSE |=> chan_q[$past(idx)] == ST_CLOSED) // see RULE_01
    else $error("close did not close channel");
  a_closed_no_xfer: assert property (chan_q[0] == ST_CLOSED ##1 chan_q[0] == ST_CLOSED |-> !rd_enable_q[0] && !wr_enable_q[0]) // see RULE_02
    else $error("closed channel still enabled");
  a_open_dir: assert property (take && cmd_op == OP_OPEN && cmd_mode == MODE_RO |=> ##1 rd_enable_q[$past(idx, 2)] && !wr_enable_q[$past(idx, 2)]) // see RULE_03
    else $error("read only open gave wrong gates");
  a_meter_wo: assert property (cmd_valid && cmd_op == OP_OPEN && num_ok && meter_owns[idx] && cmd_mode != MODE_WO |=> resp_reject_q) // see RULE_05
    else $error("meter channel opened non write only");
  a_sel_reset: assert property (take && cmd_op == OP_CMD_RESET |=> sel_q == `DCM_SEL_RST && !(chan_q[0] == ST_CLOSED) && !(chan_q[3] == ST_CLOSED)) // see RULE_07
    else $error("command reset incomplete");
  a_sel_range: assert property (sel_q >= `DCM_NUM_LO && sel_q <= `DCM_NUM_HI) // see RULE_08
    else $error("selection out of range");
  a_map_stream: assert property (take && cmd_op == OP_MAP_Q |-> ##[2:3] map_valid ##0 map_byte == `DCM_ASCII_ZERO + 8'h02) // see RULE_09
    else $error("map list did not start");
  a_reject_keeps: assert property (cmd_valid && reject |=> chan_q == $past(chan_q) && sel_q == $past(sel_q) && resp_reject_q) // see RULE_14
    else $error("rejected command changed state");
  a_sel_answer: assert property (take && cmd_op == OP_SEL_Q |=> resp_sel_q == $past(sel_q) && resp_valid_q) // see RULE_13
    else $error("selection answer wrong");

  c_close: cover property (take && cmd_op == OP_CLOSE);
  c_open_rw: cover property (take && cmd_op == OP_OPEN && cmd_mode == MODE_RW);
  c_map_done: cover property (map_last);
  c_cmd_reset: cover property (take && cmd_op == OP_CMD_RESET ##1 sel_q == `DCM_SEL_RST);
endmodule

// File: bench/dcm_host_model.sv
// Commander model that issues channel commands into the block
`timescale 1ns/1ps
module dcm_host_model (
  input wire logic clock,
  output logic cmd_valid,
  output dcm_pkg::dcm_op_t cmd_op,
  output logic cmd_has_num,
  output logic [3:0] cmd_num,
  output dcm_pkg::dcm_mode_t cmd_mode
);
  import dcm_pkg::*;
  // Quiet command port at time zero
  initial begin
    cmd_valid = 1'h0;
    cmd_op = OP_SEL_Q;
    cmd_has_num = 1'h0;
    cmd_num = 4'h1;
    cmd_mode = MODE_WO;
  end
  // Held through the taking edge; numbers stay in range unless a refusal is wanted
  // Only commands are sent here, never a transfer on a closed channel
  task automatic send(input dcm_op_t op, input logic h, input logic [3:0] n, input dcm_mode_t m);
    cmd_valid = 1'h1;
    cmd_op = op;
    cmd_has_num = h;
    cmd_num = n;
    cmd_mode = m;
    @(posedge clock);
    #1;
  endtask
  // Unused number flips so a stale value is never mistaken for a request
  task automatic idle();
    cmd_valid = 1'h0;
    cmd_num = ~cmd_num;
  endtask
endmodule

// File: bench/tb.sv
// Self-checking bench for the data channel manager
`timescale 1ns/1ps
`include "dcm_params.svh"
module tb;
  import dcm_pkg::*;
  typedef struct {dcm_op_t op; logic h; logic [3:0] n; dcm_mode_t m; logic rej; dcm_state_t st;
    logic [3:0] sel; logic [3:0] rd; logic [3:0] wr;} dcm_row_t;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic [3:0] meter_owns = 4'h0;
  logic cmd_valid, cmd_has_num, resp_valid_q, resp_reject_q, map_valid, map_last, map_busy;
  logic [3:0] cmd_num, resp_sel_q, sel_q, rd_enable_q, wr_enable_q;
  logic [7:0] map_byte;
  dcm_op_t cmd_op;
  dcm_mode_t cmd_mode;
  dcm_state_t resp_state_q;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int nb;
  // Inputs beside the state, selection and enables they should leave behind
  dcm_row_t rows [18] = '{
    '{OP_STATE_Q,1'h1,4'h1,MODE_RO,1'h0,ST_WO,4'h1,4'h0,4'hf},
    '{OP_CLOSE,1'h1,4'h2,MODE_RO,1'h0,ST_CLOSED,4'h1,4'h0,4'hd},
    '{OP_STATE_Q,1'h1,4'h2,MODE_RO,1'h0,ST_CLOSED,4'h1,4'h0,4'hd},
    '{OP_OPEN,1'h1,4'h2,MODE_RO,1'h0,ST_CLOSED,4'h1,4'h2,4'hd},
    '{OP_STATE_Q,1'h1,4'h2,MODE_RO,1'h0,ST_RO,4'h1,4'h2,4'hd},
    '{OP_SELECT,1'h1,4'h3,MODE_RO,1'h0,ST_CLOSED,4'h3,4'h2,4'hd},
    '{OP_OPEN,1'h0,4'hf,MODE_RW,1'h0,ST_CLOSED,4'h3,4'h6,4'hd},
    '{OP_STATE_Q,1'h0,4'h0,MODE_RO,1'h0,ST_RW,4'h3,4'h6,4'hd},
    '{OP_SEL_Q,1'h0,4'h0,MODE_RO,1'h0,ST_CLOSED,4'h3,4'h6,4'hd},
    '{OP_CLOSE,1'h0,4'h0,MODE_RO,1'h0,ST_CLOSED,4'h3,4'h2,4'h9},
    '{OP_OPEN,1'h1,4'h4,MODE_BAD,1'h1,ST_CLOSED,4'h3,4'h2,4'h9},
    '{OP_OPEN,1'h1,4'h0,MODE_WO,1'h1,ST_CLOSED,4'h3,4'h2,4'h9},
    '{OP_CLOSE,1'h1,4'h5,MODE_RO,1'h1,ST_CLOSED,4'h3,4'h2,4'h9},
    '{OP_SELECT,1'h0,4'h2,MODE_RO,1'h1,ST_CLOSED,4'h3,4'h2,4'h9},
    '{OP_SELECT,1'h1,4'h4,MODE_RO,1'h0,ST_CLOSED,4'h4,4'h2,4'h9},
    '{OP_CMD_RESET,1'h0,4'h0,MODE_RO,1'h0,ST_CLOSED,4'h1,4'h2,4'hd},
    '{OP_STATE_Q,1'h1,4'h3,MODE_RO,1'h0,ST_WO,4'h1,4'h2,4'hd},
    '{OP_SEL_Q,1'h0,4'h0,MODE_RO,1'h0,ST_CLOSED,4'h1,4'h2,4'hd}};
  dcm_host_model hst_u (.clock(clock), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_has_num(cmd_has_num),
    .cmd_num(cmd_num), .cmd_mode(cmd_mode));
  dcm_top dut_u (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_has_num(cmd_has_num),
    .cmd_num(cmd_num), .cmd_mode(cmd_mode), .meter_owns(meter_owns), .resp_valid_q(resp_valid_q),
    .resp_reject_q(resp_reject_q), .resp_state_q(resp_state_q), .resp_sel_q(resp_sel_q), .sel_q(sel_q),
    .rd_enable_q(rd_enable_q), .wr_enable_q(wr_enable_q), .map_valid(map_valid), .map_byte(map_byte),
    .map_last(map_last), .map_busy(map_busy));
  always #25 clock = ~clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Whole run needs well under a hundred cycles; a hang is cut at the ceiling
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    #1;
    rst_b = 1'h1;
    @(posedge clock);
    #1;
    check(wr_enable_q, 4'hf);
    for (int i = 0; i < 18; i++) begin
      hst_u.send(rows[i].op, rows[i].h, rows[i].n, rows[i].m);
      check(resp_valid_q, 1'h1);
      check(resp_reject_q, rows[i].rej);
      check(sel_q, rows[i].sel);
      if (rows[i].op == OP_STATE_Q) check(resp_state_q, rows[i].st);
      if (rows[i].op == OP_SEL_Q) check(resp_sel_q, rows[i].sel);
      hst_u.idle();
      @(posedge clock);
      #1;
      check(rd_enable_q, rows[i].rd);
      check(wr_enable_q, rows[i].wr);
    end
    // Meter-owned channel: read modes refused back to back, write-only taken
    meter_owns = 4'h1;
    hst_u.send(OP_OPEN, 1'h1, 4'h1, MODE_RO);
    check(resp_reject_q, 1'h1);
    hst_u.send(OP_OPEN, 1'h1, 4'h1, MODE_RW);
    check(resp_reject_q, 1'h1);
    hst_u.send(OP_OPEN, 1'h1, 4'h1, MODE_WO);
    check(resp_reject_q, 1'h0);
    // Map query, then commands pressed in while the list is pending
    hst_u.send(OP_MAP_Q, 1'h0, 4'h0, MODE_RO);
    check(resp_reject_q, 1'h0);
    hst_u.send(OP_SELECT, 1'h1, 4'h2, MODE_RO);
    check(resp_reject_q, 1'h1);
    hst_u.send(OP_SELECT, 1'h1, 4'h3, MODE_RO);
    check(resp_reject_q, 1'h1);
    hst_u.idle();
    check(sel_q, 4'h1);
    // First byte already stands here, so look before stepping the clock
    nb = 0;
    for (int k = 0; k < 20; k++) begin
      if (map_valid === 1'h1) begin
        check(map_byte, nb % 2 ? `DCM_ASCII_COMMA : `DCM_ASCII_ZERO + 8'(`DCM_PHYS_MAP >> (4 * nb)));
        check(map_last, nb == 6);
        check(map_busy, nb != 6);
        nb++;
      end
      @(posedge clock);
      #1;
    end
    check(8'(nb), 8'h07);
    // Move the selection and close channel one so the reset below has work to undo
    hst_u.send(OP_SELECT, 1'h1, 4'h2, MODE_RO);
    check(sel_q, 4'h2);
    hst_u.send(OP_CLOSE, 1'h1, 4'h1, MODE_RO);
    check(resp_reject_q, 1'h0);
    hst_u.send(OP_SEL_Q, 1'h0, 4'h0, MODE_RO);
    check(resp_sel_q, 4'h2);
    hst_u.idle();
    @(posedge clock);
    #1;
    check(wr_enable_q, 4'hc);
    check(rd_enable_q, 4'h2);
    // Second reset in mid-run brings back the power-up selection
    rst_b = 1'h0;
    @(posedge clock);
    #1;
    check(sel_q, 4'h1);
    check(resp_sel_q, 4'h1);
    check(rd_enable_q, 4'h0);
    check(wr_enable_q, 4'h0);
    rst_b = 1'h1;
    @(posedge clock);
    #1;
    check(wr_enable_q, 4'hf);
    check(rd_enable_q, 4'h0);
    give_verdict();
  end
endmodule
